// File: rtl/tpc_core.sv
// Timer/PWM counter core with one channel and a Wishbone slave
`timescale 1ns/1ps
module tpc_core
	import tpc_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Tick inputs from pins and system
	input  wire logic        fixed_system_tick,
	input  wire logic        external_tick_input,
	input  wire logic        debug_freeze,
	// Channel pin
	input  wire logic        chan_pin_i,
	output logic             chan_pin_o,
	output logic             chan_pin_oe,
	output logic             chan_pin_owned,
	// Interrupt requests
	output logic             overflow_irq,
	output logic             channel_irq
);
	import tpc_pkg::*;

	typedef struct packed {
		logic [7:0]  dat;
		logic        ack;
		logic        overflow_flag;
		logic        tof_arm;
		logic        overflow_irq_enable;
		logic        center_aligned_pwm;
		logic [1:0]  src;
		logic [2:0]  ps;
		logic [15:0] cnt;
		logic        dn;
		logic [TPC_PRE_W-1:0] pre;
		logic [15:0] lim;
		logic        lim_pend;
		logic        lim_pend_hi;
		logic        held;
		logic        held_hi;
		logic [15:0] cbuf;
		logic [1:0]  xs;
		logic        xs_d;
		logic [1:0]  fs;
		logic        fs_d;
		logic [1:0]  cs;
		logic        cs_d;
		logic        chf;
		logic        ch_arm;
		logic        chie;
		logic [1:0]  chm;
		logic [1:0]  chel;
		logic [15:0] chv;
		logic        chout;
		logic        choe;
		logic        chown;
		logic        tirq;
		logic        cirq;
	} tpc_state_s;

	tpc_state_s r;
	tpc_state_s n;

	logic        req;
	logic        wr;
	logic        rd;
	logic        src_tick;
	logic        pre_tick;
	logic        step;
	logic [15:0] lim_eff;
	logic [15:0] cnt_new;
	logic        dn_new;
	logic        ovf;
	logic        match;
	logic        cap_edge;
	logic        rise;
	logic        fall;
	logic [TPC_PRE_W-1:0] pre_mask;
	logic [7:0]  wbyte;

	// Bus request decode
	always_comb begin
		req   = wb_cyc_i & wb_stb_i & ~r.ack;
		wr    = req & wb_we_i & wb_sel_i[0];
		rd    = req & ~wb_we_i;
		wbyte = wb_dat_i[7:0];
	end

	// Tick source selection after synchronisers
	always_comb begin
		case (tpc_src_e'(r.src))
			TPC_SRC_BUS: src_tick = 1'b1;
			TPC_SRC_FIX: src_tick = r.fs[1] & ~r.fs_d;
			TPC_SRC_EXT: src_tick = r.xs[1] & ~r.xs_d;
			default:     src_tick = 1'b0;
		endcase
	end

	// Prescaler tap on the chosen tick
	always_comb begin
		pre_mask = TPC_PRE_W'((8'h01 << r.ps) - 8'h01);
		pre_tick = src_tick & ((r.pre & pre_mask) == pre_mask);
		step     = pre_tick & ~debug_freeze;
	end

	// Next counter value and overflow event
	always_comb begin
		lim_eff = (r.lim == TPC_RST_LIM) ? TPC_LIM_FULL : r.lim;
		cnt_new = r.cnt;
		dn_new  = r.dn;
		ovf     = 1'b0;
		if (step) begin
			if (!r.center_aligned_pwm) begin
				dn_new = 1'b0;
				if (r.cnt >= lim_eff) begin
					cnt_new = TPC_RST_CNT;
					ovf     = 1'b1;
				end else begin
					cnt_new = r.cnt + 16'h0001;
				end
			end else if (r.dn) begin
				if (r.cnt == TPC_RST_CNT) begin
					dn_new  = 1'b0;
					cnt_new = r.cnt + 16'h0001;
				end else begin
					cnt_new = r.cnt - 16'h0001;
				end
			end else if (r.cnt >= lim_eff) begin
				dn_new  = 1'b1;
				cnt_new = r.cnt - 16'h0001;
				ovf     = 1'b1;
			end else begin
				cnt_new = r.cnt + 16'h0001;
			end
		end
		// Compare match looks at the count about to be loaded
		match = step & (cnt_new == r.chv);
	end

	// Channel pin edges from the synchronised level
	always_comb begin
		rise = r.cs[1] & ~r.cs_d;
		fall = ~r.cs[1] & r.cs_d;
		case (r.chel)
			TPC_EL_A:  cap_edge = rise;
			TPC_EL_B:  cap_edge = fall;
			TPC_EL_AB: cap_edge = rise | fall;
			default:   cap_edge = 1'b0;
		endcase
	end

	// Next-state of the whole block
	always_comb begin
		n      = r;
		n.ack  = req;
		n.dat  = 8'h00;
		// Synchronisers; first stage only feeds the second
		n.xs   = {r.xs[0], external_tick_input};
		n.xs_d = r.xs[1];
		n.fs   = {r.fs[0], fixed_system_tick};
		n.fs_d = r.fs[1];
		n.cs   = {r.cs[0], chan_pin_i};
		n.cs_d = r.cs[1];
		// Prescaler and counter
		if (src_tick)
			n.pre = r.pre + 7'h01;
		n.cnt = cnt_new;
		n.dn  = dn_new;

		// Register reads
		if (rd) begin
			case (wb_adr_i)
				TPC_OFS_CTRL: begin
					n.dat = {r.overflow_flag, r.overflow_irq_enable, r.center_aligned_pwm, r.src, r.ps};
					if (r.overflow_flag)
						n.tof_arm = 1'b1;
				end
				TPC_OFS_CNT_HI, TPC_OFS_CNT_LO: begin
					// First byte snapshots, the other byte releases
					n.dat = (wb_adr_i == TPC_OFS_CNT_HI) ?
						(r.held ? r.cbuf[15:8] : r.cnt[15:8]) :
						(r.held ? r.cbuf[7:0] : r.cnt[7:0]);
					if (!debug_freeze) begin
						if (!r.held) begin
							n.held    = 1'b1;
							n.held_hi = (wb_adr_i == TPC_OFS_CNT_HI);
							n.cbuf    = r.cnt;
						end else if (r.held_hi != (wb_adr_i == TPC_OFS_CNT_HI))
							n.held = 1'b0;
					end
				end
				TPC_OFS_LIM_HI: n.dat = r.lim[15:8];
				TPC_OFS_LIM_LO: n.dat = r.lim[7:0];
				TPC_OFS_CH_SC: begin
					n.dat = {r.chf, r.chie, r.chm, r.chel, 2'h0};
					if (r.chf)
						n.ch_arm = 1'b1;
				end
				TPC_OFS_CHV_HI: n.dat = r.chv[15:8];
				TPC_OFS_CHV_LO: n.dat = r.chv[7:0];
				default:        n.dat = 8'h00;
			endcase
		end

		// Register writes
		if (wr) begin
			case (wb_adr_i)
				TPC_OFS_CTRL: begin
					n.overflow_irq_enable = wbyte[TPC_BIT_IE];
					n.center_aligned_pwm = wbyte[TPC_BIT_CENTER_ALIGNED_PWM];
					n.src  = wbyte[TPC_SRC_HI:TPC_SRC_LO];
					n.ps   = wbyte[TPC_PS_HI:TPC_PS_LO];
					n.held = 1'b0;
					// Flag clears only after an armed read
					if (r.tof_arm && !wbyte[TPC_BIT_FLAG]) begin
						n.overflow_flag     = 1'b0;
						n.tof_arm = 1'b0;
					end
				end
				TPC_OFS_CNT_HI, TPC_OFS_CNT_LO: begin
					n.cnt  = TPC_RST_CNT;
					n.dn   = 1'b0;
					n.pre  = '0;
					n.held = 1'b0;
				end
				TPC_OFS_LIM_HI, TPC_OFS_LIM_LO: begin
					// Track which byte opened the pair
					if (wb_adr_i == TPC_OFS_LIM_HI)
						n.lim[15:8] = wbyte;
					else
						n.lim[7:0] = wbyte;
					if (r.lim_pend &&
					    r.lim_pend_hi != (wb_adr_i == TPC_OFS_LIM_HI))
						n.lim_pend = 1'b0;
					else begin
						n.lim_pend    = 1'b1;
						n.lim_pend_hi = (wb_adr_i == TPC_OFS_LIM_HI);
					end
				end
				TPC_OFS_CH_SC: begin
					n.chie = wbyte[TPC_BIT_IE];
					n.chm  = wbyte[TPC_CHM_HI:TPC_CHM_LO];
					n.chel = wbyte[TPC_CHEL_HI:TPC_CHEL_LO];
					if (r.ch_arm && !wbyte[TPC_BIT_FLAG]) begin
						n.chf    = 1'b0;
						n.ch_arm = 1'b0;
					end
				end
				TPC_OFS_CHV_HI: n.chv[15:8] = wbyte;
				TPC_OFS_CHV_LO: n.chv[7:0]  = wbyte;
				default: ;
			endcase
		end

		// Overflow with no limit byte pending sets flag and restarts the clear sequence
		if (ovf && !r.lim_pend) begin
			n.overflow_flag     = 1'b1;
			n.tof_arm = 1'b0;
		end

		// Channel behaviour
		if (r.center_aligned_pwm) begin
			// Center-aligned: low-true for code A, high-true otherwise
			n.chown = (r.chel != TPC_EL_NONE);
			n.choe  = n.chown;
			n.chout = (cnt_new < r.chv) ^ (r.chel == TPC_EL_A);
			if (match) begin
				n.chf    = 1'b1;
				n.ch_arm = 1'b0;
			end
		end else if (r.chm == TPC_CHM_CAP) begin
			n.chown = (r.chel != TPC_EL_NONE);
			n.choe  = 1'b0;
			// Capture holds the count from before this step
			if (cap_edge && !debug_freeze) begin
				n.chv    = r.cnt;
				n.chf    = 1'b1;
				n.ch_arm = 1'b0;
			end
		end else if (r.chm == TPC_CHM_CMP) begin
			n.chown = (r.chel != TPC_EL_NONE);
			n.choe  = n.chown;
			if (match) begin
				n.chf    = 1'b1;
				n.ch_arm = 1'b0;
				case (r.chel)
					TPC_EL_A:  n.chout = ~r.chout;
					TPC_EL_B:  n.chout = 1'b0;
					TPC_EL_AB: n.chout = 1'b1;
					default:   n.chout = r.chout;
				endcase
			end
		end else begin
			// Edge-aligned PWM: start level at overflow, flip at match
			n.chown = (r.chel != TPC_EL_NONE);
			n.choe  = n.chown;
			if (ovf)
				n.chout = (r.chel == TPC_EL_B);
			if (match) begin
				n.chout  = (r.chel != TPC_EL_B);
				n.chf    = 1'b1;
				n.ch_arm = 1'b0;
			end
		end

		// Interrupt request levels
		n.tirq = n.overflow_flag & n.overflow_irq_enable;
		n.cirq = n.chf & n.chie;
	end

	// State register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			r      <= '0;
			r.cnt  <= TPC_RST_CNT;
			r.lim  <= TPC_RST_LIM;
			// Control fields start from their reset code
			{r.overflow_flag, r.overflow_irq_enable, r.center_aligned_pwm, r.src, r.ps} <= TPC_RST_CTRL;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from state flops
	always_comb begin
		wb_dat_o       = {24'h000000, r.dat};
		wb_ack_o       = r.ack;
		chan_pin_o     = r.chout;
		chan_pin_oe    = r.choe;
		chan_pin_owned = r.chown;
		overflow_irq   = r.tirq;
		channel_irq    = r.cirq;
	end
endmodule

// File: include/tpc_pkg.sv
// Constants and types for the timer/PWM counter core
package tpc_pkg;
	// Register byte offsets on the Wishbone bus
	localparam logic [7:0] TPC_OFS_CTRL   = 8'h00;
	localparam logic [7:0] TPC_OFS_CNT_HI = 8'h04;
	localparam logic [7:0] TPC_OFS_CNT_LO = 8'h08;
	localparam logic [7:0] TPC_OFS_LIM_HI = 8'h0C;
	localparam logic [7:0] TPC_OFS_LIM_LO = 8'h10;
	localparam logic [7:0] TPC_OFS_CH_SC  = 8'h14;
	localparam logic [7:0] TPC_OFS_CHV_HI = 8'h18;
	localparam logic [7:0] TPC_OFS_CHV_LO = 8'h1C;
	// Status/control field positions
	localparam int TPC_BIT_FLAG  = 7;
	localparam int TPC_BIT_IE    = 6;
	localparam int TPC_BIT_CENTER_ALIGNED_PWM  = 5;
	localparam int TPC_SRC_HI    = 4;
	localparam int TPC_SRC_LO    = 3;
	localparam int TPC_PS_HI     = 2;
	localparam int TPC_PS_LO     = 0;
	// Channel control field positions
	localparam int TPC_CHM_HI    = 5;
	localparam int TPC_CHM_LO    = 4;
	localparam int TPC_CHEL_HI   = 3;
	localparam int TPC_CHEL_LO   = 2;
	// Reset values and the full-range limit
	localparam logic [7:0]  TPC_RST_CTRL = 8'h00;
	localparam logic [15:0] TPC_RST_CNT  = 16'h0000;
	localparam logic [15:0] TPC_RST_LIM  = 16'h0000;
	localparam logic [15:0] TPC_LIM_FULL = 16'hFFFF;
	// Tick source codes
	typedef enum logic [1:0] {
		TPC_SRC_OFF = 2'h0,
		TPC_SRC_BUS = 2'h1,
		TPC_SRC_FIX = 2'h2,
		TPC_SRC_EXT = 2'h3
	} tpc_src_e;
	// Channel mode codes
	localparam logic [1:0] TPC_CHM_CAP = 2'h0;
	localparam logic [1:0] TPC_CHM_CMP = 2'h1;
	// Edge/level codes
	localparam logic [1:0] TPC_EL_NONE = 2'h0;
	localparam logic [1:0] TPC_EL_A    = 2'h1;
	localparam logic [1:0] TPC_EL_B    = 2'h2;
	localparam logic [1:0] TPC_EL_AB   = 2'h3;
	localparam int TPC_PRE_W = 7;
endpackage

// File: verification/tpc_pins_model.sv
// Pin-side model: fixed tick, external tick and channel pin
`timescale 1ns/1ps
module tpc_pins_model (
	// Clock and reset
	input  wire logic clock,
	input  wire logic reset_n,
	// Pin drives toward the core
	output logic      fixed_system_tick,
	output logic      external_tick_input,
	output logic      chan_pin_i
);
	logic [3:0] div_r;

	// Divider that paces every pin just after a clock edge
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			div_r <= 4'h0;
		else
			div_r <= div_r + 4'h1;
	end

	// Sixteen-clock fixed tick, eight-clock external tick
	assign fixed_system_tick   = div_r[3];
	assign external_tick_input = div_r[2];
	assign chan_pin_i          = ~div_r[1];
endmodule

// File: verification/tpc_core_asserts.sv
// Port-level checker for the counter core
`timescale 1ns/1ps
module tpc_core_chk
	import tpc_pkg::*;
(
	// Clock and reset
	input wire logic        clock,
	input wire logic        reset_n,
	// Bus side
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Pin and interrupt side
	input wire logic        chan_pin_oe,
	input wire logic        chan_pin_owned,
	input wire logic        overflow_irq
);
	logic wr_ctrl;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	// Control register write being presented
	assign wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i
		&& wb_adr_i == TPC_OFS_CTRL;

	// Bus handshake
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("request not acked next cycle");
	a_ack_cause: assert property (wb_ack_o
		|-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_unmapped_zero: assert property (wb_ack_o
		&& $past(!wb_we_i && wb_adr_i > 8'h1C) |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	// Pins and interrupt
	a_rst_quiet: assert property ($rose(reset_n)
		|-> !overflow_irq && !chan_pin_oe && !chan_pin_owned)
		else $error("outputs active after reset");
	a_irq_clear: assert property ($fell(overflow_irq)
		|-> $past(wr_ctrl, 1) || $past(wr_ctrl, 2))
		else $error("interrupt dropped without control write");
	a_oe_owned: assert property (chan_pin_oe |-> chan_pin_owned)
		else $error("pin driven while not owned");
endmodule

// File: verification/test_timer_pwm_counter_core.sv
// Self-checking bench for the counter core
`timescale 1ns/1ps
module test_timer_pwm_counter_core;
	import tpc_pkg::*;
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic        frz = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] dout;
	logic [31:0] rv;
	logic        ack;
	logic        f_tick;
	logic        x_tick;
	logic        pin_in;
	logic        irq;
	logic        cirq;
	logic        pin_o;
	logic        pin_oe;
	logic        pin_own;
	int          n_mismatch = 0;
	int          total_checks = 0;

	// Bus clock
	always #10 clock = ~clock;

	// Design and pin model
	tpc_core u_dut (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
		.fixed_system_tick(f_tick), .external_tick_input(x_tick),
		.debug_freeze(frz), .chan_pin_i(pin_in), .chan_pin_o(pin_o),
		.chan_pin_oe(pin_oe), .chan_pin_owned(pin_own),
		.overflow_irq(irq), .channel_irq(cirq));
	tpc_pins_model u_pins (.clock(clock), .reset_n(reset_n),
		.fixed_system_tick(f_tick), .external_tick_input(x_tick),
		.chan_pin_i(pin_in));

	// Verdict and end of run
	task automatic tally_and_finish(input logic tmo);
		if (tmo) n_mismatch++;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One comparison
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Classic single bus cycle, waits for ack under a bound
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int k = 0;
		@(posedge clock);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do begin
			@(posedge clock);
			k++;
		end while (ack !== 1'b1 && k < 50);
		if (ack !== 1'b1) tally_and_finish(1'b1);
		rv = dout;
		cyc <= 1'b0;
		we <= 1'b0;
		@(posedge clock);
	endtask

	// Coherent counter read, high byte first
	task automatic rd16(output logic [15:0] v);
		bus(1'b0, TPC_OFS_CNT_HI, 8'h00);
		v[15:8] = rv[7:0];
		bus(1'b0, TPC_OFS_CNT_LO, 8'h00);
		v[7:0] = rv[7:0];
	endtask

	// Counts seen over 256 clocks for one setting
	task automatic sc_rate(input logic [7:0] c, input logic z,
		input logic [15:0] e);
		logic [15:0] a;
		logic [15:0] b;
		bus(1'b1, TPC_OFS_CTRL, c);
		bus(1'b1, TPC_OFS_CNT_LO, 8'h5A);
		frz <= z;
		rd16(a);
		repeat (248) @(posedge clock);
		rd16(b);
		frz <= 1'b0;
		chk(b - a, e);
	endtask

	// Capture flag for one edge choice, counter stopped
	task automatic sc_cap(input logic [7:0] c);
		logic [15:0] a;
		logic [15:0] v;
		bus(1'b1, TPC_OFS_CH_SC, 8'h00);
		bus(1'b0, TPC_OFS_CH_SC, 8'h00);
		bus(1'b1, TPC_OFS_CH_SC, 8'h00);
		bus(1'b0, TPC_OFS_CH_SC, 8'h00);
		chk(rv[15:0], 16'h0000);
		bus(1'b1, TPC_OFS_CH_SC, c);
		repeat (20) @(posedge clock);
		bus(1'b0, TPC_OFS_CH_SC, 8'h00);
		chk(rv[15:0], {8'h00, c | 8'h80});
		chk({14'h0, pin_own, pin_oe}, 16'h0002);
		rd16(a);
		bus(1'b0, TPC_OFS_CHV_HI, 8'h00);
		v[15:8] = rv[7:0];
		bus(1'b0, TPC_OFS_CHV_LO, 8'h00);
		v[7:0] = rv[7:0];
		chk(v, a);
	endtask

	// Main sequence
	initial begin
		logic [15:0] a;
		logic [15:0] b;
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		bus(1'b0, TPC_OFS_CTRL, 8'h00);
		chk(rv[15:0], 16'h0000);
		bus(1'b0, TPC_OFS_LIM_LO, 8'h00);
		chk(rv[15:0], 16'h0000);
		rd16(a);
		chk(a, 16'h0000);
		bus(1'b0, 8'h40, 8'h00);
		chk(rv[15:0], 16'h0000);
		for (int p = 0; p < 8; p++)
			sc_rate({5'h01, p[2:0]}, 1'b0, 16'(256 >> p));
		sc_rate(8'h10, 1'b0, 16'd16);
		// Channel edge bits stay 00 while the pin feeds the counter
		sc_rate(8'h19, 1'b0, 16'd16);
		sc_rate(8'h08, 1'b1, 16'd0);
		sc_rate(8'h00, 1'b0, 16'd0);
		bus(1'b1, TPC_OFS_LIM_HI, 8'hFF);
		bus(1'b1, TPC_OFS_LIM_LO, 8'hFF);
		sc_rate(8'h08, 1'b0, 16'd256);
		// Low byte read at 0x00FC, high byte read after the carry
		bus(1'b1, TPC_OFS_CNT_LO, 8'h00);
		repeat (249) @(posedge clock);
		bus(1'b0, TPC_OFS_CNT_LO, 8'h00);
		a[7:0] = rv[7:0];
		bus(1'b0, TPC_OFS_CNT_HI, 8'h00);
		a[15:8] = rv[7:0];
		chk(a, 16'h00FC);
		// Stop the count, then clear it with any data
		bus(1'b1, TPC_OFS_CTRL, 8'h00);
		bus(1'b1, TPC_OFS_CNT_HI, 8'hFF);
		rd16(a);
		chk(a, 16'h0000);
		// Overflow, flag clear and re-arm with limit 15, divide by 128
		bus(1'b1, TPC_OFS_LIM_HI, 8'h00);
		bus(1'b1, TPC_OFS_LIM_LO, 8'h0F);
		bus(1'b1, TPC_OFS_CTRL, 8'h4F);
		bus(1'b1, TPC_OFS_CNT_LO, 8'h00);
		repeat (2200) @(posedge clock);
		chk({15'h0, irq}, 16'h0001);
		bus(1'b0, TPC_OFS_CTRL, 8'h00);
		chk(rv[15:0], 16'h00CF);
		bus(1'b1, TPC_OFS_CTRL, 8'hCF);
		bus(1'b0, TPC_OFS_CTRL, 8'h00);
		chk(rv[15:0], 16'h00CF);
		bus(1'b1, TPC_OFS_CTRL, 8'h4F);
		bus(1'b0, TPC_OFS_CTRL, 8'h00);
		chk(rv[15:0], 16'h004F);
		chk({15'h0, irq}, 16'h0000);
		repeat (2000) @(posedge clock);
		bus(1'b0, TPC_OFS_CTRL, 8'h00);
		repeat (2100) @(posedge clock);
		bus(1'b1, TPC_OFS_CTRL, 8'h4F);
		bus(1'b0, TPC_OFS_CTRL, 8'h00);
		chk(rv[15:0], 16'h00CF);
		// Center mode: period of 30 counts, channel driving its pin
		bus(1'b1, TPC_OFS_CTRL, 8'h28);
		bus(1'b1, TPC_OFS_CH_SC, 8'h04);
		bus(1'b1, TPC_OFS_CNT_LO, 8'h00);
		rd16(a);
		repeat (22) @(posedge clock);
		rd16(b);
		chk(b, a);
		chk({15'h0, pin_oe}, 16'h0001);
		bus(1'b0, TPC_OFS_CTRL, 8'h00);
		chk(rv[15:0], 16'h00A8);
		// Pending limit byte holds the flag off until paired
		bus(1'b1, TPC_OFS_CTRL, 8'h08);
		bus(1'b1, TPC_OFS_LIM_HI, 8'h00);
		bus(1'b0, TPC_OFS_CTRL, 8'h00);
		bus(1'b1, TPC_OFS_CTRL, 8'h08);
		repeat (40) @(posedge clock);
		bus(1'b0, TPC_OFS_CTRL, 8'h00);
		chk(rv[15:0], 16'h0008);
		bus(1'b1, TPC_OFS_LIM_LO, 8'h0F);
		repeat (40) @(posedge clock);
		bus(1'b0, TPC_OFS_CTRL, 8'h00);
		chk(rv[15:0], 16'h0088);
		// Compare as software timer, flag cleared while stopped
		bus(1'b1, TPC_OFS_CTRL, 8'h00);
		bus(1'b1, TPC_OFS_CH_SC, 8'h10);
		bus(1'b0, TPC_OFS_CH_SC, 8'h00);
		bus(1'b1, TPC_OFS_CH_SC, 8'h10);
		bus(1'b0, TPC_OFS_CH_SC, 8'h00);
		chk(rv[15:0], 16'h0010);
		bus(1'b1, TPC_OFS_CHV_HI, 8'h00);
		bus(1'b1, TPC_OFS_CHV_LO, 8'h05);
		bus(1'b1, TPC_OFS_CTRL, 8'h08);
		repeat (20) @(posedge clock);
		bus(1'b0, TPC_OFS_CH_SC, 8'h00);
		chk(rv[15:0], 16'h0090);
		chk({15'h0, pin_oe}, 16'h0000);
		// Toggle, clear and set actions on a 16-clock period
		bus(1'b1, TPC_OFS_CH_SC, 8'h54);
		repeat (20) @(posedge clock);
		chk({15'h0, cirq}, 16'h0001);
		chk({14'h0, pin_own, pin_oe}, 16'h0003);
		b[0] = pin_o;
		repeat (16) @(posedge clock);
		chk({15'h0, pin_o}, {15'h0, ~b[0]});
		bus(1'b1, TPC_OFS_CH_SC, 8'h58);
		repeat (20) @(posedge clock);
		chk({15'h0, pin_o}, 16'h0000);
		bus(1'b1, TPC_OFS_CH_SC, 8'h5C);
		repeat (20) @(posedge clock);
		chk({15'h0, pin_o}, 16'h0001);
		// Capture on each edge choice with the counter stopped
		bus(1'b1, TPC_OFS_CTRL, 8'h00);
		sc_cap(8'h04);
		sc_cap(8'h08);
		sc_cap(8'h0C);
		tally_and_finish(1'b0);
	end
endmodule

bind tpc_core tpc_core_chk u_chk (.clock, .reset_n, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .chan_pin_oe,
	.chan_pin_owned, .overflow_irq);
